// ==== rtl/dsc_pin_sync.sv ====
// Two-stage synchronisers and edge detection for the serial port pins
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.svh"
module dsc_pin_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [3:0] pins,
   output logic [3:0] level,
   output logic [3:0] rise,
   output logic [3:0] fall
);
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic [3:0] prev_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_r <= `DSC_PIN_IDLE;
         sync_r <= `DSC_PIN_IDLE;
         prev_r <= `DSC_PIN_IDLE;
      end else if (clk_en) begin
         meta_r <= pins;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule // dsc_pin_sync
`default_nettype wire

// ==== rtl/dsc_pkg.sv ====
// Types shared by the serial configuration port modules
package dsc_pkg;
   typedef enum logic [1:0] {ph_instr, ph_data, ph_done} dsc_phase_type;
endpackage

// ==== rtl/dsc_reg_file.sv ====
// Control, configuration and calibration registers of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.svh"
module dsc_reg_file (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   dsc_reg_if.store bus,
   input wire logic [1:0] cal_state,
   input wire logic cal_done,
   output logic [7:0] data_cfg,
   output logic [2:0] cal_divsel,
   output logic [7:0] mem_cmd,
   output logic [5:0] mem_addr,
   output logic [5:0] mem_data,
   output logic dac_current_off,
   output logic bandgap_off
);
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic srst;
   logic hit_ctrl, hit_data, hit_ver, hit_calst, hit_cmd, hit_maddr, hit_mdata;

   assign hit_ctrl = bus.addr == `DSC_ADDR_CTRL;
   assign hit_data = bus.addr == `DSC_ADDR_DATA;
   assign hit_ver = bus.addr == `DSC_ADDR_VER;
   assign hit_calst = bus.addr == `DSC_ADDR_CALST;
   assign hit_cmd = bus.addr == `DSC_ADDR_CMD;
   assign hit_maddr = bus.addr == `DSC_ADDR_MADDR;
   assign hit_mdata = bus.addr == `DSC_ADDR_MDATA;
   assign srst = ctrl_r[`DSC_CTRL_SRST];

   // New control value lands at once; the reset bit drops one cycle after it is seen
   assign ctrl_nxt = (bus.wr_en && hit_ctrl) ? bus.wdata :          // [RULE12] [RULE24]
      (srst ? (ctrl_r & ~`DSC_CTRL_SRST_MASK) : ctrl_r);             // [RULE14]
   assign bus.ctrl = ctrl_r;

   assign bus.rdata = hit_ctrl ? ctrl_r :
      hit_data ? data_cfg :
      hit_ver ? {4'h0, `DSC_HW_VERSION} :
      hit_calst ? {2'b00, cal_state, 1'b0, cal_divsel} :
      hit_cmd ? {cal_done, mem_cmd[6:0]} :
      hit_maddr ? {2'b00, mem_addr} :
      hit_mdata ? {2'b00, mem_data} : 8'h00;                         // [RULE25]

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_r <= `DSC_CTRL_RST;
         dac_current_off <= 1'b0;
         bandgap_off <= 1'b0;
      end else if (clk_en) begin
         ctrl_r <= ctrl_nxt;
         dac_current_off <= ctrl_nxt[`DSC_CTRL_PDN] | ctrl_nxt[`DSC_CTRL_SLEEP]; // [RULE18] [RULE19]
         bandgap_off <= ctrl_nxt[`DSC_CTRL_PDN];                                // [RULE18]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || (clk_en && srst)) begin                          // [RULE13]
         data_cfg <= `DSC_DATA_RST;
         cal_divsel <= `DSC_DIVSEL_RST;
         mem_cmd <= `DSC_CMD_RST;
         mem_addr <= `DSC_MADDR_RST;
         mem_data <= `DSC_MDATA_RST;
      end else if (clk_en && bus.wr_en) begin
         if (hit_data) data_cfg <= bus.wdata & `DSC_DATA_MASK;
         if (hit_calst) cal_divsel <= bus.wdata[2:0];
         if (hit_cmd) mem_cmd <= bus.wdata & `DSC_CMD_MASK;
         if (hit_maddr) mem_addr <= bus.wdata[5:0];
         if (hit_mdata) mem_data <= bus.wdata[5:0];
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_srst_self_clear: assert property (srst && clk_en |=> !ctrl_r[`DSC_CTRL_SRST]) // [RULE14]
      else $error("soft reset bit did not clear");
   a_srst_keeps_ctrl: assert property (srst && clk_en && !bus.wr_en |=> // [RULE13]
      data_cfg == `DSC_DATA_RST && mem_data == `DSC_MDATA_RST && ctrl_r[7:6] == $past(ctrl_r[7:6]))
      else $error("soft reset left a register off its default");
   a_power_down_out: assert property (clk_en && ctrl_nxt[`DSC_CTRL_PDN] |=> // [RULE18]
      bandgap_off && dac_current_off)
      else $error("power down did not shut current and reference");
endmodule // dsc_reg_file
`default_nettype wire

// ==== rtl/dsc_reg_if.sv ====
// Register access channel between the serial engine and the register file
`timescale 1ns/1ps
`default_nettype none
interface dsc_reg_if;
   logic wr_en;
   logic [12:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] ctrl;
   modport engine (output wr_en, output addr, output wdata, input rdata, input ctrl);
   modport store (input wr_en, input addr, input wdata, output rdata, output ctrl);
endinterface // dsc_reg_if
`default_nettype wire

// ==== rtl/dsc_regs.svh ====
// Offsets, field positions, reset values and timing figures of the serial configuration port
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

`define DSC_ADDR_CTRL 13'h0000
`define DSC_ADDR_DATA 13'h0002
`define DSC_ADDR_VER 13'h000d
`define DSC_ADDR_CALST 13'h000e
`define DSC_ADDR_CMD 13'h000f
`define DSC_ADDR_MADDR 13'h0010
`define DSC_ADDR_MDATA 13'h0011
`define DSC_ADDR_TOP 13'h001f

`define DSC_INS_RW 7
`define DSC_INS_CNT_HI 6
`define DSC_INS_CNT_LO 5

`define DSC_CTRL_WIRE 7
`define DSC_CTRL_ORDER 6
`define DSC_CTRL_SRST 5
`define DSC_CTRL_PRE 4
`define DSC_CTRL_PDN 3
`define DSC_CTRL_SLEEP 2
`define DSC_CTRL_MASTER_CLOCK_DISABLE 1
`define DSC_CTRL_REFERENCE_SELECT 0
`define DSC_CTRL_SRST_MASK 8'h20

`define DSC_CTRL_RST 8'h80
`define DSC_DATA_RST 8'h00
`define DSC_DATA_MASK 8'h9d
`define DSC_CMD_RST 8'h00
`define DSC_CMD_MASK 8'h4d
`define DSC_DIVSEL_RST 3'h0
`define DSC_MADDR_RST 6'h00
`define DSC_MDATA_RST 6'h3f
// Arbitrary value
`define DSC_HW_VERSION 4'h0

// Idle levels of {port reset, data in, select, serial clock}
`define DSC_PIN_IDLE 4'h2
`define DSC_SCLK_MAX_MHZ 20

`endif

// ==== rtl/dsc_serial_port.sv ====
// Serial configuration port: pin sampling, instruction and data phases, register access
//
// How it works
// [RULE1] Instruction bit 7 high means read, low means write.
// [RULE2] Instruction bits 6:5 give one to four data bytes.
// [RULE3] Low five instruction bits give start address; later addresses are generated.
// [RULE4] Incoming bits sampled on serial clock rising edges; state advances on them.
// [RULE5] Read data bits are launched on serial clock falling edges.
// [RULE6] Host keeps serial clock at or below 20 MHz.
// [RULE7] Low select starts and gates a cycle; data line released while high.
// [RULE8] Host holds select low for the whole cycle.
// [RULE9] Bit order zero, the default, sends bytes most significant bit first.
// [RULE10] Most significant first: address decrements per data byte toward 0x00.
// [RULE11] Least significant first: bits reversed, address increments toward 0x1f.
// [RULE12] Control register changes act at once, even mid-cycle.
// [RULE13] Soft reset restores all registers except the control register.
// [RULE14] Soft reset bit clears itself when the reset completes.
// [RULE15] Host should use single-byte cycles for configuration or soft reset.
// [RULE16] Wire mode one: data line bidirectional; zero: input only, separate output.
// [RULE17] Preamble bit selects one-byte or two-byte instruction (5 or 13 address bits).
// [RULE18] Power down shuts converter current and band gap reference.
// [RULE19] Sleep shuts converter current only.
// [RULE20] Clock-off bit disables the converter master clock.
// [RULE21] Reference select: zero internal band gap, one external reference.
// [RULE22] First eight rising edges (sixteen with the long preamble) carry the instruction, the rest data.
// [RULE23] Port reset pin returns to instruction start, dropping partial bytes.
// [RULE24] Each written byte lands as soon as its last bit arrives.
// [RULE25] Unmapped addresses read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.svh"
module dsc_serial_port (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic sclk,
   input wire logic port_select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_data_out,
   output logic serial_data_oe,
   input wire logic port_reset,
   input wire logic [1:0] cal_state,
   input wire logic cal_done,
   output logic [7:0] data_path_config,
   output logic [2:0] cal_divsel,
   output logic [7:0] cal_command,
   output logic [5:0] cal_mem_addr,
   output logic [5:0] cal_mem_data,
   output logic dac_current_off,
   output logic bandgap_off,
   output logic master_clock_disable,
   output logic reference_select
);

   function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b,
                                           input logic lsb);
      return lsb ? {b, cur[7:1]} : {cur[6:0], b};
   endfunction

   function automatic logic [2:0] bit_pos(input logic [2:0] n, input logic lsb);
      return lsb ? n : 3'h7 - n;
   endfunction

   function automatic logic [12:0] addr_step(input logic [12:0] a, input logic up);
      logic [12:0] n;
      n = a;
      if (up && a < `DSC_ADDR_TOP) begin
         n = a + 13'h0001;
      end else if (!up && a != `DSC_ADDR_CTRL) begin
         n = a - 13'h0001;
      end
      return n;
   endfunction

   logic [3:0] pin_level;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   dsc_pin_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pins({port_reset, sdio_in, port_select_n, sclk}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   dsc_reg_if bus ();

   dsc_reg_file u_regs (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .bus(bus.store),
      .cal_state(cal_state),
      .cal_done(cal_done),
      .data_cfg(data_path_config),
      .cal_divsel(cal_divsel),
      .mem_cmd(cal_command),
      .mem_addr(cal_mem_addr),
      .mem_data(cal_mem_data),
      .dac_current_off(dac_current_off),
      .bandgap_off(bandgap_off)
   );

   // Straight copies of control register flops
   assign master_clock_disable = bus.ctrl[`DSC_CTRL_MASTER_CLOCK_DISABLE];        // [RULE20]
   assign reference_select = bus.ctrl[`DSC_CTRL_REFERENCE_SELECT];             // [RULE21]

   dsc_pkg::dsc_phase_type phase_r;
   dsc_pkg::dsc_phase_type phase_nxt;
   logic [2:0] bit_cnt_r;
   logic [2:0] bit_cnt_nxt;
   logic [1:0] byte_cnt_r;
   logic [1:0] byte_cnt_nxt;
   logic [1:0] count_r;
   logic pre_hi_r;
   logic pre_hi_nxt;
   logic rw_r;
   logic [7:0] shift_r;
   logic [7:0] instr_hi_r;
   logic [12:0] addr_r;
   logic [12:0] addr_nxt;

   logic sclk_rise, sclk_fall, sel_idle, port_hold, sdi;
   logic lsb_first, long_pre, three_wire;
   logic active, bit_take, byte_end, pre_first, instr_end, data_end, last_byte;
   logic reading, out_bit, hi_rw;
   logic step_up;
   logic [7:0] byte_in;
   logic [7:0] hi_byte;
   logic [4:0] instr_low5;
   logic [12:0] start_addr;

   assign sclk_rise = pin_rise[0];
   assign sclk_fall = pin_fall[0];
   assign sel_idle = pin_level[1];
   assign sdi = pin_level[2];
   assign port_hold = pin_level[3];

   // Port settings are read live, so a control write steers the very next bit
   assign lsb_first = bus.ctrl[`DSC_CTRL_ORDER];                     // [RULE12]
   assign long_pre = bus.ctrl[`DSC_CTRL_PRE];
   assign three_wire = bus.ctrl[`DSC_CTRL_WIRE];

   // A high select or a held port reset parks the engine at the instruction start
   assign active = !sel_idle && !port_hold;                         // [RULE7] [RULE23]
   assign bit_take = active && sclk_rise;                           // [RULE4]
   assign byte_in = shift_in(shift_r, sdi, lsb_first);              // [RULE9] [RULE11]
   assign byte_end = bit_take && bit_cnt_r == 3'h7;
   assign pre_first = byte_end && phase_r == dsc_pkg::ph_instr && long_pre && !pre_hi_r;
   assign instr_end = byte_end && phase_r == dsc_pkg::ph_instr &&
      (!long_pre || pre_hi_r);                                      // [RULE22] [RULE17]
   assign data_end = byte_end && phase_r == dsc_pkg::ph_data;
   assign last_byte = byte_cnt_r == count_r;                        // [RULE2]

   // With the long preamble the first byte holds direction, count and upper address
   assign hi_byte = long_pre ? instr_hi_r : byte_in;
   assign hi_rw = hi_byte[`DSC_INS_RW];
   assign instr_low5 = byte_in[4:0];
   assign start_addr = long_pre ? {instr_hi_r[4:0], byte_in} :
      {8'h00, instr_low5};                                          // [RULE3] [RULE17]

   assign bus.wr_en = data_end && !rw_r;                            // [RULE1] [RULE24]
   assign bus.addr = addr_r;
   assign bus.wdata = byte_in;

   // The step after a control byte already follows the order bit just written
   assign step_up = (bus.wr_en && addr_r == `DSC_ADDR_CTRL) ?
      byte_in[`DSC_CTRL_ORDER] : lsb_first;                         // [RULE12]

   assign reading = active && phase_r == dsc_pkg::ph_data && rw_r;
   assign out_bit = bus.rdata[bit_pos(bit_cnt_r, lsb_first)];       // [RULE9]

   assign phase_nxt = !active ? dsc_pkg::ph_instr :
      instr_end ? dsc_pkg::ph_data :
      (data_end && last_byte) ? dsc_pkg::ph_done : phase_r;
   assign bit_cnt_nxt = !active ? 3'h0 : (bit_take ? bit_cnt_r + 3'h1 : bit_cnt_r);
   assign pre_hi_nxt = !active ? 1'b0 : (pre_first ? 1'b1 : pre_hi_r);
   assign byte_cnt_nxt = (!active || instr_end) ? 2'h0 :
      (data_end ? byte_cnt_r + 2'h1 : byte_cnt_r);
   assign addr_nxt = instr_end ? start_addr :
      (data_end ? addr_step(addr_r, step_up) : addr_r);             // [RULE10] [RULE11]

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_r <= dsc_pkg::ph_instr;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 2'h0;
         pre_hi_r <= 1'b0;
      end else if (clk_en) begin
         phase_r <= phase_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         byte_cnt_r <= byte_cnt_nxt;
         pre_hi_r <= pre_hi_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shift_r <= 8'h00;
         instr_hi_r <= 8'h00;
      end else if (clk_en) begin
         if (bit_take) shift_r <= byte_in;
         if (pre_first) instr_hi_r <= byte_in;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rw_r <= 1'b0;
         count_r <= 2'h0;
         addr_r <= `DSC_ADDR_CTRL;
      end else if (clk_en) begin
         if (instr_end) begin
            rw_r <= hi_rw;                                          // [RULE1]
            count_r <= hi_byte[`DSC_INS_CNT_HI:`DSC_INS_CNT_LO];    // [RULE2]
         end
         addr_r <= addr_nxt;
      end
   end

   // Read bits leave on falling edges; wire mode picks the pin that carries them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe <= 1'b0;
      end else if (clk_en) begin
         if (!reading) begin
            sdio_oe <= 1'b0;                                        // [RULE7]
            serial_data_oe <= 1'b0;
         end else if (sclk_fall) begin
            sdio_out <= out_bit;                                    // [RULE5]
            serial_data_out <= out_bit;
            sdio_oe <= three_wire;                                  // [RULE16]
            serial_data_oe <= !three_wire;
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_instr_done;
      clk_en && instr_end;
   endsequence

   sequence s_data_done;
      clk_en && data_end;
   endsequence

   a_instr_direction: assert property (s_instr_done |=> rw_r == $past(hi_rw)) // [RULE1]
      else $error("direction not taken from instruction bit 7");
   a_read_no_write: assert property (rw_r && phase_r == dsc_pkg::ph_data |-> !bus.wr_en) // [RULE1]
      else $error("register written during a read cycle");
   a_count_done: assert property (s_data_done ##0 last_byte |=> phase_r == dsc_pkg::ph_done) // [RULE2]
      else $error("cycle did not end after the counted bytes");
   a_instr_short_addr: assert property (s_instr_done ##0 !long_pre |=> // [RULE3]
      addr_r == {8'h00, $past(instr_low5)} && phase_r == dsc_pkg::ph_data)
      else $error("start address not taken from low five bits");
   a_addr_step_down: assert property (s_data_done ##0 (!step_up && addr_r != 13'h0000) |=> // [RULE10]
      addr_r == $past(addr_r) - 13'h0001)
      else $error("address did not decrement");
   a_addr_step_up: assert property (s_data_done ##0 (step_up && addr_r < 13'h001f) |=> // [RULE11]
      addr_r == $past(addr_r) + 13'h0001)
      else $error("address did not increment");
   a_write_last_bit: assert property (clk_en && active && phase_r == dsc_pkg::ph_data && // [RULE24]
      !rw_r && sclk_rise && bit_cnt_r == 3'h7 |-> bus.wr_en)
      else $error("byte not written at its last bit");
   a_idle_release: assert property (clk_en && sel_idle |=> !sdio_oe && !serial_data_oe) // [RULE7]
      else $error("data line driven while deselected");
   a_launch_on_fall: assert property (!$stable(sdio_out) |-> $past(sclk_fall)) // [RULE5]
      else $error("read bit changed away from a falling edge");
   a_four_wire_pin: assert property (clk_en && reading && sclk_fall && !three_wire |=> // [RULE16]
      !sdio_oe && serial_data_oe)
      else $error("four-wire read drove the bidirectional line");
   a_hold_restart: assert property (clk_en && port_hold |=> // [RULE23]
      phase_r == dsc_pkg::ph_instr && bit_cnt_r == 3'h0 && !pre_hi_r)
      else $error("port reset did not return to instruction start");
   a_order_follows_ctrl: assert property (s_data_done ##0 (bus.wr_en && // [RULE12]
      addr_r == `DSC_ADDR_CTRL && byte_in[`DSC_CTRL_ORDER]) |=> addr_r == 13'h0001)
      else $error("address step ignored the new bit order");
   a_addr_floor: assert property (s_data_done ##0 (!step_up && addr_r == 13'h0000) // [RULE10]
      |=> addr_r == 13'h0000)
      else $error("address stepped below the bottom");
   a_addr_ceiling: assert property (s_data_done ##0 (step_up && addr_r == 13'h001f) // [RULE11]
      |=> addr_r == 13'h001f)
      else $error("address stepped past the top");
   a_three_wire_pin: assert property (clk_en && reading && sclk_fall && three_wire |=> // [RULE16]
      sdio_oe && !serial_data_oe)
      else $error("three-wire read did not drive the bidirectional line");
   a_data_phase_start: assert property (s_instr_done |=> // [RULE22]
      bit_cnt_r == 3'h0 && byte_cnt_r == 2'h0)
      else $error("data phase did not start from a clean count");

endmodule // dsc_serial_port
`default_nettype wire

// ==== test/dsc_host_model.sv ====
// Host master model that drives the serial configuration port pins
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
   output logic sclk,
   output logic port_select_n,
   output logic sdio_in,
   output logic port_reset,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   output logic saw_oe
);
   localparam int half = 80; // 160 ns serial clock, well below 20 MHz
   logic drv = 1'b0;
   logic bq = 1'b0;
   logic fill = 1'b0;
   initial begin
      sclk = 1'b0;
      port_select_n = 1'b1;
      port_reset = 1'b0;
      saw_oe = 1'b0;
      forever #13 fill = ~fill;
   end
   // Released line toggles so stale data never reads as valid
   assign sdio_in = sdio_oe ? sdio_out : (drv ? bq : fill);

   // Direction bit 7, count bits 6:5, then bytes on rising edges
   task automatic xfer(input logic rd, input int n, input logic [12:0] a, input logic [4:0] ord,
      input logic lng, input int cut, input logic pr, input logic [31:0] wd,
      output logic [31:0] q);
      logic [7:0] ins [$];
      logic [7:0] by;
      logic o;
      int ni;
      int t;
      int j;
      int x;
      ins = {{rd, 2'(n - 1), lng ? a[12:8] : a[4:0]}};
      if (lng) ins.push_back(a[7:0]); // Low address byte of a long preamble
      ni = ins.size();
      t = 0;
      q = 'x;
      saw_oe = 1'b0;
      port_select_n = 1'b0; // Select stays low for the whole cycle
      for (int k = 0; k < ni + n && (cut == 0 || t < cut); k++) begin
         j = k - ni;
         if (k < ni) by = ins[k];
         else by = wd[8*j+:8];
         o = ord[(k < ni) ? 0 : j + 1];
         drv = !(rd && k >= ni);
         for (int i = 0; i < 8 && (cut == 0 || t < cut); i++) begin
            x = o ? i : 7 - i; // Bit order of each byte
            bq = by[x];
            #half sclk = 1'b1;
            if (k >= ni) q[8*j+x] = serial_data_oe ? serial_data_out : sdio_in;
            saw_oe |= sdio_oe;
            #half sclk = 1'b0;
            t++;
         end
      end
      if (pr) begin
         port_reset = 1'b1;
         #half port_reset = 1'b0;
      end
      #half port_select_n = 1'b1;
      drv = 1'b0;
      #(2*half);
   endtask
endmodule // dsc_host_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.svh"
module tb;
   logic clock, rst_n, clk_en, sclk, port_select_n, sdio_in, sdio_out, sdio_oe;
   logic serial_data_out, serial_data_oe, port_reset, cal_done, saw_oe;
   logic dac_current_off, bandgap_off, master_clock_disable, reference_select;
   logic [1:0] cal_state;
   logic [2:0] cal_divsel;
   logic [5:0] cal_mem_addr, cal_mem_data;
   logic [7:0] data_path_config, cal_command, ctl, d;
   logic [7:0] sh [0:31];
   logic [31:0] q;
   int fails = 0;
   int n_checks = 0;
   int a, n;

   dsc_serial_port uut (.clock, .rst_n, .clk_en, .sclk, .port_select_n, .sdio_in, .sdio_out,
      .sdio_oe, .serial_data_out, .serial_data_oe, .port_reset, .cal_state, .cal_done,
      .data_path_config, .cal_divsel, .cal_command, .cal_mem_addr, .cal_mem_data,
      .dac_current_off, .bandgap_off, .master_clock_disable, .reference_select);
   dsc_host_model host (.sclk, .port_select_n, .sdio_in, .port_reset, .sdio_out, .sdio_oe,
      .serial_data_out, .serial_data_oe, .saw_oe);

   function automatic logic [7:0] wm(input int r);
      case (r)
         2: return `DSC_DATA_MASK;
         14: return 8'h07;
         15: return `DSC_CMD_MASK;
         16, 17: return 8'h3f;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] rv(input int r);
      case (r)
         0: return ctl;
         13: return {4'h0, `DSC_HW_VERSION};
         14: return {2'h0, cal_state, 1'b0, sh[14][2:0]};
         15: return {cal_done, sh[15][6:0]};
         default: return sh[r];
      endcase
   endfunction
   function automatic int nx(input int r, input logic l);
      return l ? ((r == 31) ? 31 : r + 1) : ((r == 0) ? 0 : r - 1);
   endfunction

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic clr;
      foreach (sh[i]) sh[i] = 8'h00;
      sh[17] = {2'h0, `DSC_MDATA_RST};
   endtask
   task automatic hx(input logic r, input int m, input logic [12:0] ad, input logic [4:0] o,
      input logic lg, input int cut, input logic pr, input logic [31:0] wd);
      @(negedge clock);
      host.xfer(r, m, ad, o, lg, cut, pr, wd, q);
      chk(sdio_oe, 1'b0); // Pin released with select high
      chk(serial_data_oe, 1'b0); // Output released with select high
   endtask
   task automatic setc(input logic [7:0] v);
      hx(0, 1, 13'h0000, {5{ctl[6]}}, 0, 0, 0, v); // Single-byte control write
      ctl = v & 8'hdf;
      if (v[5]) clr(); // Control register survives soft reset
   endtask
   task automatic wr(input int r, input int m, input logic [31:0] wd);
      hx(0, m, 13'(r), {5{ctl[6]}}, 0, 0, 0, wd);
      for (int k = 0; k < m; k++) begin
         sh[r] = wd[8*k+:8] & wm(r);
         r = nx(r, ctl[6]);
      end
   endtask
   task automatic rd(input int r, input int m);
      hx(1, m, 13'(r), {5{ctl[6]}}, 0, 0, 0, 0);
      for (int k = 0; k < m; k++) begin
         chk(q[8*k+:8], rv(r)); // Stepped read data
         r = nx(r, ctl[6]);
      end
   endtask
   task automatic outs;
      chk(data_path_config, sh[2]); // Data path configuration
      chk(cal_divsel, sh[14][2:0]); // Divider field
      chk(cal_command, sh[15]); // Command bits
      chk(cal_mem_addr, sh[16][5:0]); // Memory address
      chk(cal_mem_data, sh[17][5:0]); // Memory data
      chk(dac_current_off, ctl[3] | ctl[2]); // Current off
      chk(bandgap_off, ctl[3]); // Band gap off
      chk(master_clock_disable, ctl[1]); // Master clock off
      chk(reference_select, ctl[0]); // Reference source
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #1ms;
      fails++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      cal_state = 2'h0;
      cal_done = 1'b0;
      ctl = `DSC_CTRL_RST;
      clr();
      void'($urandom(79055));
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      outs();
      rd(17, 4);
      rd(4, 2);
      for (int b = 0; b < 4; b++) begin
         setc(8'h80 | (8'h01 << b));
         outs();
      end
      repeat (30) begin
         @(posedge clock);
         cal_state <= 2'($urandom);
         cal_done <= 1'($urandom);
         setc({1'b1, 1'($urandom), 6'h00});
         n = $urandom_range(4, 1);
         a = ctl[6] ? $urandom_range(31, 1) : $urandom_range(31, n);
         wr(a, n, $urandom);
         outs();
         rd(a, n);
      end
      // Order flips after the control byte; later bytes go upward, low bit first
      setc(8'h80);
      d = 8'($urandom);
      hx(0, 3, 13'h0000, 5'b01100, 0, 0, 0, {8'h00, d, 16'hffc0});
      ctl = 8'hc0;
      sh[2] = d & wm(2);
      outs();
      rd(2, 1);
      setc(8'he5);
      outs();
      rd(0, 1);
      // Port reset or select abort in mid-byte writes nothing
      hx(0, 1, 13'h0002, {5{ctl[6]}}, 0, 12, 1, 32'hff);
      outs();
      hx(0, 1, 13'h0002, {5{ctl[6]}}, 0, 13, 0, 32'hff);
      outs();
      wr(2, 1, 32'hff);
      outs();
      setc(8'h00);
      wr(17, 2, $urandom);
      rd(17, 2);
      chk(saw_oe, 1'b0); // Input-only pin in four-wire mode
      setc(8'h80);
      rd(17, 2);
      chk(saw_oe, 1'b1); // Pin driven in three-wire reads
      setc(8'h90);
      d = 8'($urandom);
      hx(0, 1, 13'h0002, 5'h00, 1, 0, 0, {24'h0, d});
      sh[2] = d & wm(2);
      outs();
      hx(1, 1, 13'h0002, 5'h00, 1, 0, 0, 0);
      chk(q[7:0], rv(2)); // Two-byte instruction read
      hx(0, 1, 13'h0000, 5'h00, 1, 0, 0, 32'h80);
      ctl = 8'h80;
      rd(0, 1);
      finish_test();
   end
endmodule // tb
`default_nettype wire
